// ### logic/cfe_pkg.sv
// Constants, types and tables shared by the forward channel encoder.
package cfe_pkg;

  // ----------------------------------------------------------------
  // Frame lengths in bits at the width of the bit counter, then the last copy index, sync pattern and generator.
  // ----------------------------------------------------------------
  localparam logic [6:0]  DOT_FIRST  = 7'h65;  // Dotting before the first voice copy.
  localparam logic [6:0]  DOT_REP    = 7'h25;  // Dotting before each later voice copy.
  localparam logic [6:0]  DOT_CTL    = 7'h0a;  // Dotting ahead of a control frame.
  localparam logic [6:0]  SYNC_LEN   = 7'h0b;
  localparam logic [6:0]  WORD_LEN   = 7'h28;
  localparam logic [6:0]  DSAT_LEN   = 7'h18;
  localparam logic [3:0]  COPY_LAST  = 4'ha;   // Index of the eleventh voice copy.
  localparam logic [10:0] SYNC_PAT   = 11'h712;
  localparam logic [11:0] BCH_POLY   = 12'h539; // Generator taps below x^12.

  // ----------------------------------------------------------------
  // Values after reset.
  // ----------------------------------------------------------------
  localparam logic [15:0] DIV_RST    = 16'h0000;
  localparam logic [7:0]  REP_RST    = 8'h00;
  localparam logic [39:0] SH_RST     = 40'h00_0000_0000;

  // ----------------------------------------------------------------
  // Standard supervisory sequences and their signaling-tone inverses.
  // ----------------------------------------------------------------
  localparam logic [23:0] DSAT_TAB [7] = '{24'h2556cb, 24'h255b2b, 24'h256a9b,
    24'h25ad4d, 24'h26ab2b, 24'h26b2ad, 24'h2969ab};
  localparam logic [23:0] DST_TAB  [7] = '{24'hdaa934, 24'hdaa4d4, 24'hda9564,
    24'hda52b2, 24'hd954d4, 24'hd94d52, 24'hd69654};

  // ----------------------------------------------------------------
  // Types.
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    PH_IDLE = 3'h0,
    PH_DOT  = 3'h1,
    PH_SYNC = 3'h3,
    PH_WORD = 3'h2,
    PH_DSAT = 3'h6
  } cfe_phase_t;

  typedef enum logic [1:0] {
    SM_SINGLE = 2'h0,
    SM_BURST  = 2'h1,
    SM_CONT   = 2'h2,
    SM_STEP   = 2'h3
  } cfe_mode_t;

  typedef struct packed {
    logic send;
    logic stop;
    logic fill_go;
    logic fill_stop;
    logic dsat_go;
    logic dsat_stop;
  } cfe_cmd_t;

  typedef struct packed {
    logic        voice;     // 1 voice channel, 0 control channel.
    logic        narrow;    // 1 narrowband mode.
    logic        msg_sel;   // 1 message, 0 signaling tone.
    logic        pol_inv;
    cfe_mode_t   mode;
    logic [7:0]  bursts;
    logic [15:0] rate_div;  // Clock cycles per bit, minus one.
    logic [2:0]  dsat_sel;
    logic [27:0] msg_fvc;
    logic [27:0] msg_a;
    logic [27:0] msg_b;
    logic [27:0] fill_a;
    logic [27:0] fill_b;
  } cfe_cfg_t;

  typedef struct packed {
    logic bit_val;
    logic level_pos;  // 1 drives the output above the rest level.
  } cfe_sym_t;

  typedef struct packed {
    logic msg_busy;
    logic fill_on;
    logic dsat_on;
    logic sat_on;
  } cfe_stat_t;

endpackage

// ### logic/cfe_encoder.sv
// Forward control and voice channel bit stream encoder.
`timescale 1ns/1ps
// Function
// R1: Control message lines are whole seven-digit lines; streams A and B equal length.
// R2: Wide voice word goes out 11 times: 101 or 37 dotting, sync, 40 bits.
// R3: Voice message digits are 2 type bits then 26 information bits.
// R4: Supervisory tone runs on the wide voice channel except during a message.
// R5: Narrow mode appends 12 parity bits and sends the 40-bit word on send.
// R6: Digital supervisory sequence halts during a transfer and resumes afterward.
// R7: Selector sends message, or the inverse of the configured supervisory sequence.
// R8: Seven fixed signaling tone patterns, each the complement of a standard sequence.
// R9: Normal polarity maps one to positive, zero to negative; inverted swaps.
// R10: Supervisory sequence repeats its 24 bits until stopped.
// R11: After a control message the filler starts and runs until stopped.
// R12: Send filler starts filler words A and B; stop filler ends it.
// R13: Send mode gives single, burst count, or continuous; step acts as single.
// R14: Stop ends the message transmission in progress.
// R15: Every voice message digit must be filled before sending.
// R16: Bit rate comes from the data rate setting.
// R17: Filler words are 28 bits; dotting, sync and parity are added here.
// R18: Parity is the 12-bit BCH remainder, sent MSB first after the data.
module cfe_encoder (
  input  wire logic              clk,
  input  wire logic              reset_n,
  input  wire cfe_pkg::cfe_cfg_t cfg,
  input  wire cfe_pkg::cfe_cmd_t cmd,
  input  wire logic              out_ready,
  output logic                   out_valid,
  output cfe_pkg::cfe_sym_t      out_sym,
  output cfe_pkg::cfe_stat_t     stat
);

  // ----------------------------------------------------------------
  // Code word helpers.
  // ----------------------------------------------------------------

  // Remainder of the 28 data bits over the 12-bit generator.
  function automatic logic [11:0] cfe_par(input logic [27:0] d);
    logic [11:0] r;
    logic        fb;
    r = '0;
    for (int i = 27; i >= 0; i--)
    begin
      fb = d[i] ^ r[11];
      r  = {r[10:0], 1'b0};
      if (fb)
        r = r ^ cfe_pkg::BCH_POLY;
    end
    return r;
  endfunction

  // Type and information bits lead, parity follows MSB first.
  function automatic logic [39:0] cfe_cw(input logic [27:0] d);
    return {d, cfe_par(d)}; // [R3] [R17] [R18]
  endfunction

  // ----------------------------------------------------------------
  // State and declarations.
  // ----------------------------------------------------------------
  cfe_pkg::cfe_phase_t phase_q, phase_d;
  logic [6:0]          cnt_q, cnt_d;
  logic [39:0]         sh_q, sh_d;
  logic [3:0]          copy_q, copy_d;
  logic [7:0]          rep_q, rep_d;
  logic                wb_q, wb_d;
  logic                msg_q, msg_d;
  logic                fill_q, fill_d;
  logic                dsat_q, dsat_d;
  logic                dst_q, dst_d;
  logic                sat_q;
  logic [15:0]         div_q;
  logic [1:0]          bcnt_q;
  cfe_pkg::cfe_sym_t   b0_q, b1_q;
  cfe_pkg::cfe_sym_t   in_sym;
  logic                in_ready;
  logic                step;
  logic                push;
  logic                pop;
  logic                amps_v;
  logic                emit_bit;
  logic [23:0]         dsat_pat;
  logic                launch;

  assign amps_v   = cfg.voice && !cfg.narrow;
  assign dsat_pat = (cfg.dsat_sel < 3'h7) ? cfe_pkg::DSAT_TAB[cfg.dsat_sel]
                                          : cfe_pkg::DSAT_TAB[0];

  // ----------------------------------------------------------------
  // Bit rate divider.
  // ----------------------------------------------------------------

  // The divider waits at zero while the buffer is full, so a stalled
  // receiver holds the sequencer's stepping instead of dropping a bit.
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      div_q <= cfe_pkg::DIV_RST;
    else if (step)
      div_q <= cfg.rate_div; // [R16]
    else if (div_q != cfe_pkg::DIV_RST)
      div_q <= div_q - 16'h0001;
  end

  assign step = (div_q == cfe_pkg::DIV_RST) && in_ready;
  assign push = step && (phase_q != cfe_pkg::PH_IDLE);

  // ----------------------------------------------------------------
  // Bit selection and polarity.
  // ----------------------------------------------------------------

  // Dotting alternates with the low count bit; odd lengths start on one.
  always_comb
  begin
    unique case (phase_q)
      cfe_pkg::PH_DOT:  emit_bit = cnt_q[0];
      cfe_pkg::PH_SYNC: emit_bit = cfe_pkg::SYNC_PAT[cnt_q[3:0] - 4'h1];
      default:          emit_bit = sh_q[39];
    endcase
  end

  assign in_sym.bit_val   = emit_bit;
  assign in_sym.level_pos = emit_bit ^ cfg.pol_inv; // [R9]

  // ----------------------------------------------------------------
  // Sequencer next state.
  // ----------------------------------------------------------------

  // Segment ends pick the following segment; commands then override,
  // so a stop in the same cycle as a pass end always wins.
  always_comb
  begin
    phase_d = phase_q;
    cnt_d   = cnt_q;
    sh_d    = sh_q;
    copy_d  = copy_q;
    rep_d   = rep_q;
    wb_d    = wb_q;
    msg_d   = msg_q;
    fill_d  = fill_q;
    dsat_d  = dsat_q;
    dst_d   = dst_q;
    launch  = 1'b0;
    if (step)
    begin
      cnt_d = cnt_q - 7'h01;
      sh_d  = {sh_q[38:0], 1'b0};
      if (cnt_q == 7'h01 || phase_q == cfe_pkg::PH_IDLE)
      begin
        unique case (phase_q)
          cfe_pkg::PH_DOT:
          begin
            phase_d = cfe_pkg::PH_SYNC;
            cnt_d   = cfe_pkg::SYNC_LEN;
          end
          cfe_pkg::PH_SYNC:
          begin
            phase_d = cfe_pkg::PH_WORD;
            cnt_d   = cfe_pkg::WORD_LEN;
            wb_d    = 1'b1;
            if (cfg.voice)
              sh_d = cfe_cw(cfg.msg_fvc); // [R2]
            else
              sh_d = cfe_cw(msg_q ? cfg.msg_a : cfg.fill_a); // [R17]
          end
          cfe_pkg::PH_WORD:
          begin
            if (!cfg.voice && wb_q)
            begin
              cnt_d = cfe_pkg::WORD_LEN;
              wb_d  = 1'b0;
              sh_d  = cfe_cw(msg_q ? cfg.msg_b : cfg.fill_b); // [R12]
            end
            else if (msg_q && amps_v && copy_q != cfe_pkg::COPY_LAST)
            begin
              copy_d  = copy_q + 4'h1;
              phase_d = cfe_pkg::PH_DOT;
              cnt_d   = cfe_pkg::DOT_REP; // [R2]
            end
            else
              launch = 1'b1;
          end
          default:
            launch = 1'b1;
        endcase
        // A message pass ends here; count it against the send mode.
        if (launch && msg_q && phase_q != cfe_pkg::PH_IDLE)
        begin
          copy_d = 4'h0;
          if (cfg.mode != cfe_pkg::SM_CONT)
          begin
            if (rep_q <= 8'h01)
            begin
              msg_d  = 1'b0; // [R13]
              fill_d = fill_q || !cfg.voice; // [R11]
            end
            else
              rep_d = rep_q - 8'h01;
          end
        end
        if (launch)
        begin
          phase_d = cfe_pkg::PH_IDLE;
          dst_d   = 1'b0;
          if (msg_d && cfg.voice && cfg.narrow)
          begin
            cnt_d = cfe_pkg::WORD_LEN;
            if (cfg.msg_sel)
            begin
              phase_d = cfe_pkg::PH_WORD;
              sh_d    = cfe_cw(cfg.msg_fvc); // [R5]
            end
            else
            begin
              phase_d = cfe_pkg::PH_DSAT;
              cnt_d   = cfe_pkg::DSAT_LEN;
              dst_d   = 1'b1;
              sh_d    = {~dsat_pat, 16'h0000}; // [R7] [R8]
            end
          end
          else if (msg_d || (!cfg.voice && fill_d))
          begin
            phase_d = cfe_pkg::PH_DOT;
            if (!cfg.voice)
              cnt_d = cfe_pkg::DOT_CTL;
            else
              cnt_d = (copy_d == 4'h0) ? cfe_pkg::DOT_FIRST : cfe_pkg::DOT_REP; // [R2]
          end
          else if (cfg.voice && cfg.narrow && dsat_d)
          begin
            phase_d = cfe_pkg::PH_DSAT; // [R6] [R10]
            cnt_d   = cfe_pkg::DSAT_LEN;
            sh_d    = {dsat_pat, 16'h0000};
          end
        end
      end
    end
    // Operator commands.
    if (cmd.fill_go)
      fill_d = 1'b1; // [R12]
    if (cmd.dsat_go)
      dsat_d = 1'b1;
    if (cmd.dsat_stop)
    begin
      dsat_d = 1'b0;
      if (phase_q == cfe_pkg::PH_DSAT && !dst_q)
        phase_d = cfe_pkg::PH_IDLE;
    end
    if (cmd.fill_stop)
    begin
      fill_d = 1'b0; // [R12]
      if (!msg_q && !cfg.voice)
        phase_d = cfe_pkg::PH_IDLE;
    end
    if (cmd.send)
    begin
      msg_d   = 1'b1;
      copy_d  = 4'h0;
      phase_d = cfe_pkg::PH_IDLE; // [R6]
      rep_d   = (cfg.mode == cfe_pkg::SM_BURST) ? cfg.bursts : 8'h01; // [R13]
    end
    if (cmd.stop)
    begin
      msg_d   = 1'b0; // [R14]
      phase_d = cfe_pkg::PH_IDLE;
    end
  end

  // ----------------------------------------------------------------
  // Sequencer registers.
  // ----------------------------------------------------------------

  // Segment position and shifted word.
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      phase_q <= cfe_pkg::PH_IDLE;
      cnt_q   <= 7'h00;
      sh_q    <= cfe_pkg::SH_RST;
      copy_q  <= 4'h0;
      rep_q   <= cfe_pkg::REP_RST;
      wb_q    <= 1'b0;
      dst_q   <= 1'b0;
    end
    else
    begin
      phase_q <= phase_d;
      cnt_q   <= cnt_d;
      sh_q    <= sh_d;
      copy_q  <= copy_d;
      rep_q   <= rep_d;
      wb_q    <= wb_d;
      dst_q   <= dst_d;
    end
  end

  // Activity flags; the tone is registered from the same next value as the message flag.
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      msg_q  <= 1'b0;
      fill_q <= 1'b0;
      dsat_q <= 1'b0;
      sat_q  <= 1'b0;
    end
    else
    begin
      msg_q  <= msg_d;
      fill_q <= fill_d;
      dsat_q <= dsat_d;
      sat_q  <= amps_v && !msg_d; // [R4]
    end
  end

  assign stat.msg_busy = msg_q;
  assign stat.fill_on  = fill_q;
  assign stat.dsat_on  = dsat_q;
  assign stat.sat_on   = sat_q;

  // ----------------------------------------------------------------
  // Two-entry output buffer.
  // ----------------------------------------------------------------
  assign in_ready  = (bcnt_q != 2'h2);
  assign out_valid = (bcnt_q != 2'h0);
  assign out_sym   = b0_q;
  assign pop       = out_valid && out_ready;

  // Entry zero is always the head, so the data output comes from a flop.
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      bcnt_q <= 2'h0;
      b0_q   <= '0;
      b1_q   <= '0;
    end
    else
    begin
      unique case ({push, pop})
        2'b10:
        begin
          if (bcnt_q == 2'h0)
            b0_q <= in_sym;
          else
            b1_q <= in_sym;
          bcnt_q <= bcnt_q + 2'h1;
        end
        2'b01:
        begin
          b0_q   <= b1_q;
          bcnt_q <= bcnt_q - 2'h1;
        end
        2'b11:
        begin
          if (bcnt_q == 2'h1)
            b0_q <= in_sym;
          else
          begin
            b0_q <= b1_q;
            b1_q <= in_sym;
          end
        end
        default:
          bcnt_q <= bcnt_q;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Assertions.
  // ----------------------------------------------------------------
  sequence s_seg_end;
    step && cnt_q == 7'h01;
  endsequence

  sequence s_stall;
    div_q == cfe_pkg::DIV_RST && !in_ready;
  endsequence

  AST_DOT_FIRST: assert property (@(posedge clk) disable iff (!reset_n) // [R2]
    (step && phase_q == cfe_pkg::PH_IDLE && msg_q && amps_v && !cmd.stop && !cmd.send)
    |=> (phase_q == cfe_pkg::PH_DOT && cnt_q == 7'h65))
    else $error("first voice copy lacks 101 dotting bits");

  AST_SYNC: assert property (@(posedge clk) disable iff (!reset_n) // [R2]
    (s_seg_end and (phase_q == cfe_pkg::PH_DOT && !cmd.stop && !cmd.send && !cmd.fill_stop))
    |=> (phase_q == cfe_pkg::PH_SYNC && cnt_q == 7'h0b))
    else $error("dotting not followed by 11-bit sync");

  AST_PARITY: assert property (@(posedge clk) disable iff (!reset_n) // [R18]
    (s_seg_end and (phase_q == cfe_pkg::PH_SYNC && !cmd.stop && !cmd.send && !cmd.fill_stop))
    |=> (sh_q[11:0] == cfe_par(sh_q[39:12]) && cnt_q == 7'h28))
    else $error("word loaded with wrong parity");

  AST_POL: assert property (@(posedge clk) disable iff (!reset_n) // [R9]
    push ##1 (bcnt_q == 2'h1)
    |-> (out_sym.level_pos == (out_sym.bit_val ^ $past(cfg.pol_inv))))
    else $error("polarity mapping wrong");

  // The tone flag is registered from the same next value as the message flag,
  // so the two are compared in the same cycle.
  AST_SAT_OFF: assert property (@(posedge clk) disable iff (!reset_n) // [R4]
    msg_q |-> !sat_q)
    else $error("supervisory tone on during message");

  AST_DSAT_HALT: assert property (@(posedge clk) disable iff (!reset_n) // [R6]
    msg_q |-> !(phase_q == cfe_pkg::PH_DSAT && !dst_q))
    else $error("supervisory sequence not halted during transfer");

  AST_DST_TAB: assert property (@(posedge clk) disable iff (!reset_n) // [R8]
    (cfg.dsat_sel < 3'h7) |-> (~dsat_pat == cfe_pkg::DST_TAB[cfg.dsat_sel]))
    else $error("signaling tone not the complement of sequence");

  AST_DSAT_LOOP: assert property (@(posedge clk) disable iff (!reset_n) // [R10]
    (s_seg_end and (phase_q == cfe_pkg::PH_DSAT && dsat_q && !msg_q && !dst_q
     && cfg.voice && cfg.narrow && cmd == '0))
    |=> (phase_q == cfe_pkg::PH_DSAT && cnt_q == 7'h18))
    else $error("supervisory sequence did not repeat");

  AST_FILL_AFTER: assert property (@(posedge clk) disable iff (!reset_n) // [R11]
    (msg_q && !msg_d && !cmd.stop && !cfg.voice && !cmd.fill_stop) |=> fill_q)
    else $error("filler not started after control message");

  AST_STOP: assert property (@(posedge clk) disable iff (!reset_n) // [R14]
    (cmd.stop && !cmd.send) |=> (!msg_q && phase_q == cfe_pkg::PH_IDLE))
    else $error("stop did not end message");

  // Commands may still abort a segment during a stall, so they are left out here.
  AST_STALL: assert property (@(posedge clk) disable iff (!reset_n) // [R16]
    (s_stall and (cmd == '0))
    |=> (div_q == cfe_pkg::DIV_RST && $stable(phase_q) && $stable(cnt_q) && $stable(sh_q)))
    else $error("sequencer advanced while buffer full");

endmodule

// ### dv/cfe_sink_model.sv
// Receiver model standing in for the audio generator behind the encoder.
`timescale 1ns/1ps
module cfe_sink_model (
  input  wire logic              clk,
  input  wire logic              reset_n,
  input  wire logic              slow,
  input  wire logic              out_valid,
  input  wire cfe_pkg::cfe_sym_t out_sym,
  output logic                   out_ready
);
  cfe_pkg::cfe_sym_t rx_q [$];
  logic [1:0]        gap_q;

  // ------------------------------------------------------------
  // Ready pattern and capture.
  // ------------------------------------------------------------
  // Slow mode takes one bit in three, so at full bit rate the encoder's buffer fills and must hold.
  always @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      gap_q     <= 2'h0;
      out_ready <= 1'b0;
    end
    else
    begin
      if (out_valid && out_ready)
        rx_q.push_back(out_sym);
      gap_q     <= (gap_q == 2'h2) ? 2'h0 : gap_q + 2'h1;
      out_ready <= !slow || (gap_q == 2'h1);
    end
  end
endmodule

// ### dv/tb_top.sv
// Self-checking bench for the forward channel encoder.
`timescale 1ns/1ps
module tb_top;
  logic               clk;
  logic               reset_n;
  logic               slow;
  logic               out_ready;
  logic               out_valid;
  cfe_pkg::cfe_cfg_t  cfg;
  cfe_pkg::cfe_cmd_t  cmd;
  cfe_pkg::cfe_sym_t  out_sym;
  cfe_pkg::cfe_stat_t stat;
  int                 fails;
  int                 samples_checked;
  int                 cycles;
  logic               exp_q [$];
  localparam logic [5:0] SEND = 6'h20, STOP = 6'h10, FGO = 6'h08, FSTOP = 6'h04;
  localparam logic [5:0] DGO = 6'h02, DSTOP = 6'h01;
  localparam logic [23:0] DST_LIST [7] = '{24'hdaa934, 24'hdaa4d4, 24'hda9564,
    24'hda52b2, 24'hd954d4, 24'hd94d52, 24'hd69654};

  cfe_encoder DUT (.clk(clk), .reset_n(reset_n), .cfg(cfg), .cmd(cmd),
    .out_ready(out_ready), .out_valid(out_valid), .out_sym(out_sym), .stat(stat));
  cfe_sink_model sink (.clk(clk), .reset_n(reset_n), .slow(slow),
    .out_valid(out_valid), .out_sym(out_sym), .out_ready(out_ready));

  // ------------------------------------------------------------
  // Clock and hang guard.
  // ------------------------------------------------------------
  // The ceiling leaves ample room over the longest scenario.
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 80000)
    begin
      fails++;
      give_verdict();
    end
  end

  // ------------------------------------------------------------
  // Shared tasks.
  // ------------------------------------------------------------
  task automatic give_verdict();
    if (fails == 0 && samples_checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (exp !== got)
    begin
      fails++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Parity is the remainder of the data shifted up by twelve places.
  function automatic logic [11:0] parity(input logic [27:0] d);
    logic [11:0] r;
    logic        fb;
    r = 12'h000;
    for (int i = 27; i >= 0; i--)
    begin
      fb = d[i] ^ r[11];
      r  = {r[10:0], 1'b0} ^ (fb ? 12'h539 : 12'h000);
    end
    return r;
  endfunction

  task automatic push_word(input logic [39:0] v, input int n);
    for (int i = n - 1; i >= 0; i--)
      exp_q.push_back(v[i]);
  endtask

  // Dotting alternates, ending on a one just before the sync pattern.
  task automatic push_frame(input int dots, input logic [27:0] d);
    for (int i = dots; i >= 1; i--)
      exp_q.push_back(i[0]);
    if (dots > 0)
      push_word(40'(11'b11100010010), 11);
    push_word({d, parity(d)}, 40);
  endtask

  task automatic start();
    repeat (4) @(posedge clk);
    #1;
    exp_q.delete();
    sink.rx_q.delete();
  endtask

  task automatic pulse(input logic [5:0] c);
    @(posedge clk);
    #1 cmd = c;
    @(posedge clk);
    #1 cmd = '0;
  endtask

  task automatic wait_bits(input int n);
    for (int i = 0; i < 20000 && sink.rx_q.size() < n; i++)
      @(posedge clk);
    #1;
    check("bits in time", 32'd1, (sink.rx_q.size() >= n) ? 32'd1 : 32'd0);
  endtask

  task automatic wait_idle();
    for (int i = 0; i < 20000 && stat.msg_busy !== 1'b0; i++)
      @(posedge clk);
    repeat (8) @(posedge clk);
    #1;
    check("idle in time", 32'd0, stat.msg_busy);
  endtask

  // Compares the expected bits from the start, or finds them anywhere, and checks levels.
  task automatic judge(input string what, input logic pol, input bit anywhere);
    int hit;
    int bad;
    hit = -1;
    wait_bits(exp_q.size());
    for (int b = 0; b + exp_q.size() <= sink.rx_q.size() && hit < 0; b++)
    begin
      bad = 0;
      foreach (exp_q[i])
        if (sink.rx_q[b + i].bit_val !== exp_q[i])
          bad++;
      if (bad == 0)
        hit = b;
      if (!anywhere)
        break;
    end
    check(what, 32'd0, (hit == 0 || (anywhere && hit > 0)) ? 32'd0 : 32'd1);
    bad = 0;
    foreach (sink.rx_q[i])
      if (sink.rx_q[i].level_pos !== (sink.rx_q[i].bit_val ^ pol))
        bad++;
    check("level", 32'd0, bad);
  endtask

  // ------------------------------------------------------------
  // Scenarios.
  // ------------------------------------------------------------
  task automatic t_narrow();
    int t0;
    cfg.voice = 1'b1;
    cfg.narrow = 1'b1;
    cfg.msg_sel = 1'b1;
    cfg.pol_inv = 1'b1;
    cfg.rate_div = 16'h0003;
    slow = 1'b1;
    start();
    push_frame(0, cfg.msg_fvc);
    t0 = cycles;
    pulse(SEND);
    check("busy", 32'd1, stat.msg_busy);
    wait_idle();
    check("rate", 32'd1, (cycles - t0 >= 156) ? 32'd1 : 32'd0);
    judge("narrow word", 1'b1, 0);
    check("single count", 32'd40, sink.rx_q.size());
    cfg.pol_inv = 1'b0;
    cfg.rate_div = 16'h0000;
    slow = 1'b0;
  endtask

  // A slow receiver at full bit rate fills the buffer, so the tones also test the stall.
  task automatic t_tones();
    cfg.msg_sel = 1'b0;
    slow = 1'b1;
    for (int i = 0; i < 7; i++)
    begin
      cfg.dsat_sel = 3'(i);
      start();
      push_word(40'(DST_LIST[i]), 24);
      pulse(SEND);
      wait_idle();
      judge("tone", 1'b0, 0);
      check("tone count", 32'd24, sink.rx_q.size());
    end
    cfg.msg_sel = 1'b1;
    slow = 1'b0;
  endtask

  task automatic t_dsat();
    cfg.dsat_sel = 3'h2;
    start();
    push_word(40'(cfe_pkg::DSAT_TAB[2]), 24);
    push_word(40'(cfe_pkg::DSAT_TAB[2]), 24);
    pulse(DGO);
    check("dsat on", 32'd1, stat.dsat_on);
    judge("dsat repeat", 1'b0, 0);
    start();
    push_frame(0, cfg.msg_fvc);
    push_word(40'(cfe_pkg::DSAT_TAB[2]), 24);
    pulse(SEND);
    wait_idle();
    wait_bits(160);
    judge("dsat resumes", 1'b0, 1);
    check("dsat still on", 32'd1, stat.dsat_on);
    pulse(DSTOP);
    check("dsat off", 32'd0, stat.dsat_on);
    start();
    repeat (60) @(posedge clk);
    check("dsat silent", 32'd0, sink.rx_q.size());
  endtask

  task automatic t_wide();
    cfg.narrow = 1'b0;
    @(posedge clk);
    #1;
    check("sat idle", 32'd1, stat.sat_on);
    start();
    push_frame(101, cfg.msg_fvc);
    repeat (10) push_frame(37, cfg.msg_fvc);
    pulse(SEND);
    check("sat off", 32'd0, stat.sat_on);
    wait_idle();
    judge("wide pass", 1'b0, 0);
    check("wide count", 32'd1032, sink.rx_q.size());
    check("sat back", 32'd1, stat.sat_on);
  endtask

  task automatic t_control();
    cfg.voice = 1'b0;
    start();
    push_frame(10, cfg.msg_a);
    push_frame(0, cfg.msg_b);
    push_frame(10, cfg.fill_a);
    push_frame(0, cfg.fill_b);
    pulse(SEND);
    wait_idle();
    check("fill after msg", 32'd1, stat.fill_on);
    judge("msg then filler", 1'b0, 0);
    pulse(FSTOP);
    check("fill stop", 32'd0, stat.fill_on);
    start();
    push_frame(10, cfg.fill_a);
    push_frame(0, cfg.fill_b);
    push_frame(10, cfg.fill_a);
    pulse(FGO);
    check("fill on", 32'd1, stat.fill_on);
    judge("filler", 1'b0, 0);
    pulse(FSTOP);
    start();
    repeat (60) @(posedge clk);
    check("fill silent", 32'd0, sink.rx_q.size());
  endtask

  task automatic t_modes();
    cfg.voice = 1'b1;
    cfg.narrow = 1'b1;
    cfg.mode = cfe_pkg::SM_BURST;
    cfg.bursts = 8'h03;
    start();
    repeat (3) push_frame(0, cfg.msg_fvc);
    pulse(SEND);
    wait_idle();
    judge("burst", 1'b0, 0);
    check("burst count", 32'd120, sink.rx_q.size());
    cfg.mode = cfe_pkg::SM_CONT;
    start();
    pulse(SEND);
    wait_bits(100);
    check("cont busy", 32'd1, stat.msg_busy);
    pulse(STOP);
    check("stop busy", 32'd0, stat.msg_busy);
    start();
    repeat (60) @(posedge clk);
    check("stop silent", 32'd0, sink.rx_q.size());
  endtask

  // ------------------------------------------------------------
  // Main sequence.
  // ------------------------------------------------------------
  // Whole seven-digit words throughout, one line in each stream.
  initial
  begin
    fails = 0;
    samples_checked = 0;
    cycles = 0;
    reset_n = 1'b0;
    slow = 1'b0;
    cmd = '0;
    cfg = '0;
    cfg.msg_fvc = 28'h9a5c3e1;
    cfg.msg_a = 28'h4c1b7d2;
    cfg.msg_b = 28'h83e06a5;
    cfg.fill_a = 28'h1f2e3d4;
    cfg.fill_b = 28'hc5b6a79;
    repeat (16) @(posedge clk);
    #1 reset_n = 1'b1;
    t_narrow();
    t_tones();
    t_dsat();
    t_wide();
    t_control();
    t_modes();
    give_verdict();
  end
endmodule
